//--- rtl/hgl_pkg.sv
/*
 * Shared constants and types for the host glue that decodes host addresses
 * and services interrupts of two cascaded display managers.
 * Assumes a 16-bit host bus with byte address bits 6:1 carrying the codes.
 */
package hgl_pkg;
    // Port select codes, host address bits 2:1
    localparam logic [1:0] PORT_INSTR = 2'h0;
    localparam logic [1:0] PORT_BLOCK = 2'h1;
    localparam logic [1:0] PORT_POINTER = 2'h2;
    localparam logic [1:0] PORT_DATA = 2'h3;
    // Chip select codes, host address bits 4:3
    localparam logic [1:0] SEL_BOTH = 2'h0;
    localparam logic [1:0] SEL_FIRST = 2'h1;
    localparam logic [1:0] SEL_SECOND = 2'h2;
    localparam logic [1:0] SEL_RSVD = 2'h3;
    // Data path codes, host address bits 6:5
    localparam logic [1:0] PATH_BCAST = 2'h0;
    localparam logic [1:0] PATH_PLANE = 2'h1;
    localparam logic [1:0] PATH_PIXEL = 2'h2;
    localparam logic [1:0] PATH_RSVD = 2'h3;
    // Field positions in the host address
    localparam int PORT_LSB = 1;
    localparam int SEL_LSB = 3;
    localparam int PATH_LSB = 5;
    // Interrupt priority level driven for this source, arbitrary default
    localparam logic [2:0] IRQ_LEVEL = 3'h4;
    // Interrupt acknowledge function code space
    localparam logic [2:0] FC_CPU_SPACE = 3'h7;
    // Width of the host read data and manager status word
    localparam int ACK_W = 16;
    // Number of managers
    localparam int NUM_DEV = 2;

    // Bus cycle states
    typedef enum logic [1:0]
    {
        HGL_IDLE = 2'b00,
        HGL_ACCESS = 2'b01,
        HGL_DONE = 2'b11
    } hgl_state_t;

    // Data buffer enables
    typedef struct packed
    {
        logic bcast;
        logic plane;
        logic pixel;
    } hgl_buf_t;
endpackage

//--- rtl/hgl_dec_if.sv
/*
 * Carrier for the decoded address fields between the glue's own modules.
 * Assumes the decoder is purely combinational.
 */
`timescale 1ns/1ps
interface hgl_dec_if;
    logic [1:0] portSel;
    logic [1:0] chipSel;
    logic [1:0] pathSel;
    logic [hgl_pkg::NUM_DEV-1:0] devSelect;
    hgl_pkg::hgl_buf_t bufEnable;
    logic legal;
    modport dec (input portSel, input chipSel, input pathSel,
        output devSelect, output bufEnable, output legal);
    modport use_side (output portSel, output chipSel, output pathSel,
        input devSelect, input bufEnable, input legal);
endinterface

//--- rtl/hgl_sync.sv
/*
 * Two flip-flop level synchroniser for one device-clock signal.
 * Assumes the input may change at any time relative to ref_clk.
 */
`timescale 1ns/1ps
module hgl_sync
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstSync_n,
    // Level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    import hgl_pkg::*;
    logic stage1;
    logic next_stage1;
    logic next_syncOut;

    // Next values of the two stages
    always_comb
    begin
        next_stage1 = asyncIn;
        next_syncOut = stage1;
    end

    // Register stages
    always_ff @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            stage1 <= 1'b0;
            syncOut <= 1'b0;
        end
        else
        begin
            stage1 <= next_stage1;
            syncOut <= next_syncOut;
        end
    end
endmodule

//--- rtl/hgl_decode.sv
/*
 * Combinational decode of chip select and data path fields.
 * Assumes the caller qualifies the results with a live bus cycle.
 */
`timescale 1ns/1ps
module hgl_decode
(
    // Decoded fields
    hgl_dec_if.dec decBus
);
    import hgl_pkg::*;

    // Chip select and buffer decode
    always_comb
    begin
        decBus.devSelect = '0;
        decBus.bufEnable = '0;
        case (decBus.chipSel)
            SEL_BOTH: decBus.devSelect = 2'b11;
            SEL_FIRST: decBus.devSelect = 2'b01;
            SEL_SECOND: decBus.devSelect = 2'b10;
            default: decBus.devSelect = 2'b00;
        endcase
        case (decBus.pathSel)
            PATH_BCAST: decBus.bufEnable.bcast = 1'b1;
            PATH_PLANE: decBus.bufEnable.plane = 1'b1;
            PATH_PIXEL: decBus.bufEnable.pixel = 1'b1;
            default: decBus.bufEnable = '0;
        endcase
        decBus.legal = (decBus.chipSel != SEL_RSVD) && (decBus.pathSel != PATH_RSVD);
        if (!decBus.legal)
        begin
            decBus.devSelect = '0;
            decBus.bufEnable = '0;
        end
    end
endmodule

//--- rtl/hgl_glue.sv
/*
 * Host glue for two cascaded display managers: address decode to ports,
 * chip selects and data buffers, plus interrupt priority and autovector.
 * Assumes host cycles are synchronous to ref_clk; manager clocks are not.
 */
`timescale 1ns/1ps
module hgl_glue
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Host bus cycle
    input wire logic hostStrobe,
    input wire logic hostWrite,
    input wire logic [6:0] hostAddr,
    input wire logic [2:0] hostFc,
    input wire logic [2:0] hostAckLevel,
    output logic hostAck,
    output logic hostAvec,
    output logic [2:0] hostIpl,
    output logic [hgl_pkg::ACK_W-1:0] hostRdData,
    // Host view of the request lines
    output logic instrFifoReady,
    output logic blockFifoReady,
    // Manager pins
    output logic [hgl_pkg::NUM_DEV-1:0] devCs_n,
    output logic [1:0] devPort,
    output logic devRd_n,
    output logic devWr_n,
    input wire logic [hgl_pkg::ACK_W-1:0] devStatus,
    // Data buffer enables
    output hgl_pkg::hgl_buf_t bufEnable,
    // Raw device requests
    input wire logic devIrq,
    input wire logic instruction_fifo_request,
    input wire logic block_fifo_request
);
    import hgl_pkg::*;

    logic rstMeta_n;
    logic rstSync_n;
    logic irqSync;
    hgl_state_t state;
    hgl_state_t next_state;
    logic next_hostAck;
    logic next_hostAvec;
    logic [2:0] next_hostIpl;
    logic [ACK_W-1:0] next_hostRdData;
    logic [NUM_DEV-1:0] next_devCs_n;
    logic [1:0] next_devPort;
    logic next_devRd_n;
    logic next_devWr_n;
    hgl_buf_t next_bufEnable;
    logic iackCycle;
    logic iackOurs;
    logic readOne;
    hgl_dec_if decBus();

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // Request synchronisers
    hgl_sync syncIrq
    (
        .ref_clk(ref_clk),
        .rstSync_n(rstSync_n),
        .asyncIn(devIrq),
        .syncOut(irqSync)
    );
    hgl_sync syncInstr
    (
        .ref_clk(ref_clk),
        .rstSync_n(rstSync_n),
        .asyncIn(instruction_fifo_request),
        .syncOut(instrFifoReady)
    );
    hgl_sync syncBlock
    (
        .ref_clk(ref_clk),
        .rstSync_n(rstSync_n),
        .asyncIn(block_fifo_request),
        .syncOut(blockFifoReady)
    );

    // Field extraction for the decoder
    assign decBus.portSel = hostAddr[PORT_LSB+1:PORT_LSB];
    assign decBus.chipSel = hostAddr[SEL_LSB+1:SEL_LSB];
    assign decBus.pathSel = hostAddr[PATH_LSB+1:PATH_LSB];

    hgl_decode decoder
    (
        .decBus(decBus)
    );

    // Cycle classification
    assign iackCycle = hostStrobe && (hostFc == FC_CPU_SPACE);
    assign iackOurs = iackCycle && (hostAckLevel == IRQ_LEVEL);
    assign readOne = decBus.devSelect == 2'b01 || decBus.devSelect == 2'b10;

    // Next bus cycle state and pins
    always_comb
    begin
        next_state = state;
        next_hostAck = 1'b0;
        next_hostAvec = 1'b0;
        next_hostRdData = hostRdData;
        next_devCs_n = '1;
        next_devPort = devPort;
        next_devRd_n = 1'b1;
        next_devWr_n = 1'b1;
        next_bufEnable = '0;
        next_hostIpl = irqSync ? IRQ_LEVEL : 3'h0;
        case (state)
            HGL_IDLE:
            begin
                if (iackOurs)
                begin
                    next_hostAvec = 1'b1;
                    next_state = HGL_DONE;
                end
                else if (iackCycle)
                begin
                    next_state = HGL_DONE;
                end
                else if (hostStrobe && !decBus.legal)
                begin
                    next_hostAck = 1'b1;
                    next_hostRdData = '0;
                    next_state = HGL_DONE;
                end
                else if (hostStrobe && (hostWrite || readOne))
                begin
                    // Reads need one manager so only one drives the bus
                    next_devCs_n = ~decBus.devSelect;
                    next_devPort = decBus.portSel;
                    next_devRd_n = hostWrite;
                    next_devWr_n = !hostWrite;
                    next_bufEnable = decBus.bufEnable;
                    next_state = HGL_ACCESS;
                end
                else if (hostStrobe)
                begin
                    next_hostAck = 1'b1;
                    next_hostRdData = '0;
                    next_state = HGL_DONE;
                end
            end
            HGL_ACCESS:
            begin
                next_devCs_n = devCs_n;
                next_devRd_n = devRd_n;
                next_devWr_n = devWr_n;
                next_bufEnable = bufEnable;
                next_hostAck = 1'b1;
                if (!devRd_n)
                begin
                    next_hostRdData = devStatus;
                end
                next_state = HGL_DONE;
            end
            HGL_DONE:
            begin
                if (!hostStrobe)
                begin
                    next_state = HGL_IDLE;
                end
            end
            default: next_state = HGL_IDLE;
        endcase
    end

    // Register bus cycle state and pins
    always_ff @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            state <= HGL_IDLE;
            hostAck <= 1'b0;
            hostAvec <= 1'b0;
            hostIpl <= 3'h0;
            hostRdData <= '0;
            devCs_n <= '1;
            devPort <= PORT_INSTR;
            devRd_n <= 1'b1;
            devWr_n <= 1'b1;
            bufEnable <= '0;
        end
        else
        begin
            state <= next_state;
            hostAck <= next_hostAck;
            hostAvec <= next_hostAvec;
            hostIpl <= next_hostIpl;
            hostRdData <= next_hostRdData;
            devCs_n <= next_devCs_n;
            devPort <= next_devPort;
            devRd_n <= next_devRd_n;
            devWr_n <= next_devWr_n;
            bufEnable <= next_bufEnable;
        end
    end

    // Level follows the synchronised request one cycle later
    AST_IPL_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        1'b1 |=> hostIpl == ($past(irqSync) ? IRQ_LEVEL : 3'h0))
        else $error("priority level does not follow interrupt request");

    // Autovector only answers our level
    AST_AVEC_CAUSE: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        $rose(hostAvec) |-> $past(iackOurs) && $past(state) == HGL_IDLE)
        else $error("autovector without matching acknowledge");

    // Acknowledge of our level gives autovector next cycle
    AST_AVEC_GIVEN: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (state == HGL_IDLE && iackOurs) |=> hostAvec && !hostAck)
        else $error("missing autovector");

    // Never both managers on a read
    AST_ONE_READER: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        !devRd_n |-> $onehot(~devCs_n))
        else $error("read with several managers selected");

    // Broadcast write reaches both managers
    AST_BCAST_WRITE: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (state == HGL_IDLE && hostStrobe && hostWrite && !iackCycle
        && hostAddr[4:3] == SEL_BOTH && hostAddr[6:5] != PATH_RSVD)
        |=> devCs_n == 2'b00 && !devWr_n)
        else $error("broadcast write did not select both managers");

    // Reserved codes never touch the pins
    AST_RSVD_QUIET: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (state == HGL_IDLE && hostStrobe && !iackCycle && !decBus.legal)
        |=> devCs_n == 2'b11 && bufEnable == '0 ##1 devCs_n == 2'b11)
        else $error("reserved code drove a select or buffer");

    // Port code carried to the managers
    AST_PORT_PASS: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        $fell(devWr_n) |-> devPort == $past(hostAddr[2:1]))
        else $error("port code not passed through");

    // Path and select decode
    AST_PATH_SEL: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        bufEnable != '0 |-> $onehot(bufEnable) && devCs_n != 2'b11)
        else $error("bad buffer enable pattern");

    // Status read answered within two cycles
    AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        $fell(devRd_n) |=> hostAck && hostRdData == $past(devStatus))
        else $error("status read not returned");

    // Cycle done answer lasts one cycle only
    AST_ACK_PULSE: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        hostAck |=> !hostAck)
        else $error("cycle done answer longer than one cycle");

    // Autovector answer lasts one cycle only
    AST_AVEC_PULSE: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        hostAvec |=> !hostAvec)
        else $error("autovector answer longer than one cycle");

    // Between cycles no select, strobe or buffer is active
    AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        state == HGL_IDLE |-> devCs_n == 2'b11 && devRd_n && devWr_n && bufEnable == '0)
        else $error("manager pins active while idle");

    // Broadcast read refused without touching the managers
    AST_BCAST_READ: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (state == HGL_IDLE && hostStrobe && !hostWrite && !iackCycle && hostAddr[4:3] == SEL_BOTH)
        |=> hostAck && devRd_n && devCs_n == 2'b11)
        else $error("broadcast read reached the managers");

    // Interrupt acknowledge cycles never select a manager
    AST_IACK_QUIET: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (state == HGL_IDLE && iackCycle) |=> devCs_n == 2'b11 && !hostAck)
        else $error("acknowledge cycle selected a manager");
endmodule

//--- testbench/hgl_dev_model.sv
/*
 * Behavioural pair of cascaded display managers seen from the host glue.
 * Assumes the glue drives registered selects and strobes; no write data
 * reaches the managers, so an acknowledge write clears every pending bit.
 */
`timescale 1ns/1ps
module hgl_dev_model
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Manager pins
    input wire logic [1:0] devCs_n,
    input wire logic [1:0] devPort,
    input wire logic devRd_n,
    input wire logic devWr_n,
    output logic [15:0] devStatus,
    output logic devIrq,
    output logic instruction_fifo_request,
    output logic block_fifo_request,
    // Bench controls
    input wire logic [9:0] raise,
    input wire logic [1:0] instrSpace,
    input wire logic [1:0] blockSpace
);
    import hgl_pkg::*;
    logic [9:0] pending;
    logic [9:0] maskOn;
    logic [15:0] lastOut;
    logic driveBus;
    assign maskOn = 10'h3FF;
    // Pending causes: set by events, cleared by broadcast acknowledge write
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            pending <= 10'h000;
        else if (!devWr_n && devCs_n == 2'h0 && devPort == PORT_DATA)
            pending <= raise;
        else
            pending <= pending | raise;
    end
    // Request stays up while any enabled cause is pending
    assign devIrq = |(pending & maskOn);
    // Status drives only for a single selected manager
    assign driveBus = !devRd_n && devPort == PORT_INSTR && ^devCs_n;
    always_comb
    begin
        if (driveBus)
            devStatus = {6'h00, pending};
        else
            devStatus = ~lastOut;
    end
    // Released bus keeps changing so stale data never matches
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            lastOut <= 16'h0000;
        else
            lastOut <= devStatus;
    end
    // Open-drain requests with pull-up form a wired AND
    assign instruction_fifo_request = &instrSpace;
    assign block_fifo_request = &blockSpace;
endmodule

//--- testbench/host_address_decode_interrupt_glue_bench.sv
/*
 * Self-checking bench for the host glue with a two-manager partner model.
 * Assumes the glue raises selects on the taking edge and
 * acknowledge one later, and answers refusals and autovector at once.
 */
`timescale 1ns/1ps
module host_address_decode_interrupt_glue_bench;
    import hgl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hostStrobe = 1'b0;
    logic hostWrite = 1'b0;
    logic [6:0] hostAddr = 7'h00;
    logic [2:0] hostFc = 3'h1;
    logic [2:0] hostAckLevel = 3'h0;
    logic [9:0] raise = 10'h000;
    logic [1:0] instrSpace = 2'h3;
    logic [1:0] blockSpace = 2'h3;
    logic hostAck, hostAvec, instrFifoReady, blockFifoReady, devRd_n, devWr_n;
    logic devIrq, fifoReqI, fifoReqB, seenRd, seenWr, gotAvec;
    logic [2:0] hostIpl, seenBuf, anyBuf;
    logic [15:0] hostRdData, devStatus, rdData;
    logic [1:0] devCs_n, devPort, seenCs, seenPort;
    hgl_buf_t bufEnable;
    int ackAt, csAt;
    int n_mismatch = 0;
    int tests_run = 0;

    hgl_glue i_dut
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .hostStrobe(hostStrobe),
        .hostWrite(hostWrite), .hostAddr(hostAddr), .hostFc(hostFc),
        .hostAckLevel(hostAckLevel), .hostAck(hostAck), .hostAvec(hostAvec),
        .hostIpl(hostIpl), .hostRdData(hostRdData), .instrFifoReady(instrFifoReady),
        .blockFifoReady(blockFifoReady), .devCs_n(devCs_n), .devPort(devPort),
        .devRd_n(devRd_n), .devWr_n(devWr_n), .devStatus(devStatus),
        .bufEnable(bufEnable), .devIrq(devIrq), .instruction_fifo_request(fifoReqI),
        .block_fifo_request(fifoReqB)
    );

    hgl_dev_model i_dev
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .devCs_n(devCs_n), .devPort(devPort),
        .devRd_n(devRd_n), .devWr_n(devWr_n), .devStatus(devStatus), .devIrq(devIrq),
        .instruction_fifo_request(fifoReqI), .block_fifo_request(fifoReqB),
        .raise(raise), .instrSpace(instrSpace), .blockSpace(blockSpace)
    );

    // Free-running 200 MHz clock
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Counts and verdict
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One host cycle: strobe held until answered or for eight cycles, then dropped for a cycle
    task automatic bus(input logic wr, input logic [6:0] addr, input logic [2:0] fc,
        input logic [2:0] lvl);
        ackAt = 0;
        csAt = 0;
        seenCs = 2'h3;
        seenBuf = 3'h0;
        anyBuf = 3'h0;
        @(posedge ref_clk);
        hostStrobe <= 1'b1;
        hostWrite <= wr;
        hostAddr <= addr;
        hostFc <= fc;
        hostAckLevel <= lvl;
        for (int k = 1; k <= 8 && ackAt == 0; k++)
        begin
            @(posedge ref_clk);
            #1;
            anyBuf = anyBuf | bufEnable;
            if (devCs_n !== 2'h3 && csAt == 0)
            begin
                csAt = k;
                seenCs = devCs_n;
                seenBuf = bufEnable;
                seenPort = devPort;
                seenRd = devRd_n;
                seenWr = devWr_n;
            end
            if (hostAck === 1'b1 || hostAvec === 1'b1)
            begin
                ackAt = k;
                gotAvec = hostAvec;
                rdData = hostRdData;
            end
        end
        @(posedge ref_clk);
        hostStrobe <= 1'b0;
        #1;
        check("answer pulse", 16'({hostAck, hostAvec}), 16'h0000);
        check("select release", 16'(devCs_n), 16'h0003);
        @(posedge ref_clk);
    endtask

    // Bounded wait on the priority level; running out ends the run
    task automatic waitIpl(input logic [2:0] lvl);
        for (int k = 0; k < 20 && hostIpl !== lvl; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        if (hostIpl !== lvl)
        begin
            check("level wait", 16'(hostIpl), 16'(lvl));
            test_done();
        end
    endtask

    // Every legal select, path and port as a write
    task automatic t_decode();
        logic [1:0] csExp;
        for (int s = 0; s < 3; s++)
            for (int p = 0; p < 3; p++)
                for (int q = 0; q < 4; q++)
                begin
                    csExp = (s == 0) ? 2'h0 : (s == 1) ? 2'h2 : 2'h1;
                    bus(1'b1, {p[1:0], s[1:0], q[1:0], 1'b0}, 3'h1, 3'h0);
                    check("select", 16'(seenCs), 16'(csExp));
                    check("buffer", 16'(seenBuf), 16'(3'h4 >> p));
                    check("port", 16'(seenPort), 16'(q));
                    check("write strobe", 16'({seenWr, seenRd}), 16'h0001);
                    check("ack cycle", 16'(ackAt - csAt), 16'h0001);
                end
    endtask

    // Reserved select, reserved path, broadcast read
    task automatic t_reserved();
        logic [6:0] addrs [3] = '{7'h18, 7'h68, 7'h00};
        for (int i = 0; i < 3; i++)
        begin
            bus(i != 2, addrs[i], 3'h1, 3'h0);
            check("reserved select", 16'(csAt), 16'h0000);
            check("reserved buffer", 16'(anyBuf), 16'h0000);
            check("reserved ack", 16'(ackAt), 16'h0001);
            check("refused data", rdData, 16'h0000);
        end
    endtask

    // Raise, autovector, status read, broadcast acknowledge
    task automatic t_irq();
        raise <= 10'h205;
        @(posedge ref_clk);
        raise <= 10'h000;
        waitIpl(IRQ_LEVEL);
        check("priority level", 16'(hostIpl), 16'(IRQ_LEVEL));
        bus(1'b0, 7'h00, FC_CPU_SPACE, IRQ_LEVEL - 3'h1);
        check("foreign level", 16'(ackAt), 16'h0000);
        bus(1'b0, 7'h00, FC_CPU_SPACE, IRQ_LEVEL);
        check("autovector", 16'({gotAvec, 4'(ackAt)}), 16'h0011);
        bus(1'b0, 7'h08, 3'h1, 3'h0);
        check("read strobe", 16'({seenRd, seenCs}), 16'h0002);
        check("status", rdData, 16'h0205);
        bus(1'b1, 7'h06, 3'h1, 3'h0);
        waitIpl(3'h0);
        check("level cleared", 16'(hostIpl), 16'h0000);
        bus(1'b0, 7'h10, 3'h1, 3'h0);
        check("status cleared", rdData, 16'h0000);
    endtask

    // Wired request lines seen through the synchronisers
    task automatic t_fifo();
        instrSpace <= 2'h1;
        blockSpace <= 2'h2;
        repeat (6) @(posedge ref_clk);
        #1;
        check("fifo ready low", 16'({instrFifoReady, blockFifoReady}), 16'h0000);
        @(posedge ref_clk);
        instrSpace <= 2'h3;
        blockSpace <= 2'h3;
        repeat (6) @(posedge ref_clk);
        #1;
        check("fifo ready high", 16'({instrFifoReady, blockFifoReady}), 16'h0003);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("idle pins", 16'({devCs_n, devRd_n, devWr_n, hostAck, hostAvec, hostIpl,
            bufEnable}), 16'h0F00);
        t_decode();
        t_reserved();
        t_irq();
        t_fifo();
        test_done();
    end
endmodule
